// ==== core/urp_port_status.sv ====
// root hub port two status and control register
//
// Notes on behaviour
// - bit 8 reads actual port power
// - power bit reads one without switching
// - writing one to bit 8 powers port
// - writing one to bit 9 removes power
// - bit 9 reads low speed device
// - reserved bits read zero
// - bit 4 shows reset; write starts it
// - bit 3 mirrors overload input pin when the per-port guard is present, else zero
// - writing one to bit 3 starts resume
// - bit 2 suspended; write one suspends
// - bit 1 enabled; write one enables
// - bit 0 connected; fixed device reads one
// - writing one to bit 0 disables
// - controller bus reset zeroes register except bit 16 for a fixed device and bit 8 without switching
// - bit 20 set when reset finishes
// - bit 19 overload change, write-one clear
// - bit 18 set when resume completes
// - bit 17 set on hardware disable
// - bit 16 attach change, write-one clear
// - fixed device: bit 16 resets to one
`timescale 1ns/1ps
`include "urp_map.svh"
module urp_port_status
    import urp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic controller_bus_reset_state,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic device_attached,
    input wire logic device_is_slow,
    input wire logic overload_input_pin,
    input wire logic power_switch_absent,
    input wire logic overload_guard_absent,
    input wire logic overload_guard_per_port,
    input wire logic device_fixed_setting,
    output logic port_power_drive,
    output logic port_reset_drive,
    output logic port_resume_drive,
    output logic port_suspend_drive
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_r;
    logic rst_n_r;

    // two stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic conn_r;
    logic en_r;
    logic susp_r;
    logic rst_r;
    logic pwr_r;
    logic slow_r;
    logic ovl_r;
    logic atch_r;
    logic enlost_r;
    logic rsmdone_r;
    logic ovlchg_r;
    logic rstdone_r;
    logic init_r;
    urp_seq_e seq_r;
    urp_seq_e seq_nxt;
    logic tmr_done;

    ////////////////////////////////////////////////////////////////////////
    // write decode
    wire logic hit = (reg_addr == `URP_OFF_PORT2);
    wire logic wr = reg_wr && hit;
    wire logic [31:0] w1 = wr ? reg_wdata : 32'h00000000;
    wire logic bus_rst = controller_bus_reset_state;
    wire logic conn_eff = device_attached || device_fixed_setting;
    wire logic conn_edge = conn_eff != conn_r;
    wire logic ovl_valid = !overload_guard_absent && overload_guard_per_port;
    wire logic ovl_now = ovl_valid && overload_input_pin;
    // hardware disables the port on disconnect or overload
    wire logic hw_disable = en_r && (!conn_eff || ovl_now);
    wire logic pwr_on = power_switch_absent || pwr_r;
    wire logic start_rst = w1[`URP_B_RST] && conn_eff && seq_r == URP_IDLE;
    wire logic start_rsm = w1[`URP_B_OVL] && susp_r && seq_r == URP_IDLE;
    wire logic rst_fin = seq_r == URP_RESETTING && tmr_done;
    wire logic rsm_fin = seq_r == URP_RESUMING && tmr_done;

    // a new sequence loads the shared timer
    wire logic tmr_load = start_rst || start_rsm;
    wire logic [`URP_CNT_W-1:0] tmr_val = start_rst ? `URP_CNT_W'(`URP_RST_CYC)
                                                    : `URP_CNT_W'(`URP_RSM_CYC);

    urp_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequence control
    always_comb
    begin
        seq_nxt = seq_r;
        case (seq_r)
            URP_IDLE:
            begin
                if (start_rst)
                    seq_nxt = URP_RESETTING;
                else if (start_rsm)
                    seq_nxt = URP_RESUMING;
            end
            URP_RESETTING:
            begin
                if (tmr_done)
                    seq_nxt = URP_IDLE;
            end
            URP_RESUMING:
            begin
                if (tmr_done)
                    seq_nxt = URP_IDLE;
            end
            default:
                seq_nxt = URP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            seq_r <= URP_IDLE;
        else if (bus_rst)
            seq_r <= URP_IDLE;
        else
            seq_r <= seq_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits; events set wins over write-one clear
    wire logic en_nxt = rst_fin ? 1'b1 :
                        (hw_disable || w1[`URP_B_CONN]) ? 1'b0 :
                        (w1[`URP_B_EN] && conn_eff) ? 1'b1 : en_r;
    wire logic susp_nxt = rsm_fin ? 1'b0 :
                          (w1[`URP_B_SUSP] && en_r) ? 1'b1 : susp_r;
    wire logic pwr_nxt = w1[`URP_B_PWR] ? 1'b1 :
                         w1[`URP_B_SLOW] ? 1'b0 : pwr_r;
    wire logic atch_nxt = conn_edge || (atch_r && !w1[`URP_B_ATCH]);
    wire logic enlost_nxt = hw_disable || (enlost_r && !w1[`URP_B_ENLOST]);
    wire logic rsmdone_nxt = rsm_fin || (rsmdone_r && !w1[`URP_B_RSMDONE]);
    wire logic ovlchg_nxt = (ovl_now != ovl_r) || (ovlchg_r && !w1[`URP_B_OVLCHG]);
    wire logic rstdone_nxt = rst_fin || (rstdone_r && !w1[`URP_B_RSTDONE]);

    // bus reset state returns the register to zero, attach change to the fixed setting
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            {conn_r, en_r, susp_r, pwr_r, slow_r, ovl_r} <= 6'h00;
            {atch_r, enlost_r, rsmdone_r, ovlchg_r, rstdone_r} <= 5'h00;
            init_r <= 1'b1;
        end
        else if (bus_rst || init_r)
        begin
            {conn_r, en_r, susp_r, pwr_r, slow_r, ovl_r} <= 6'h00;
            {enlost_r, rsmdone_r, ovlchg_r, rstdone_r} <= 4'h0;
            atch_r <= device_fixed_setting;
            init_r <= 1'b0;
        end
        else
        begin
            conn_r <= conn_eff;
            slow_r <= device_is_slow;
            ovl_r <= ovl_now;
            en_r <= en_nxt;
            susp_r <= susp_nxt;
            pwr_r <= pwr_nxt;
            atch_r <= atch_nxt;
            enlost_r <= enlost_nxt;
            rsmdone_r <= rsmdone_nxt;
            ovlchg_r <= ovlchg_nxt;
            rstdone_r <= rstdone_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; reserved fields are hard zero
    wire logic rst_act = seq_r == URP_RESETTING;
    urp_word_t rd_word;
    always_comb
    begin
        rd_word = `URP_RESET_VAL;
        rd_word[`URP_B_CONN] = conn_r;
        rd_word[`URP_B_EN] = en_r;
        rd_word[`URP_B_SUSP] = susp_r;
        rd_word[`URP_B_OVL] = ovl_r;
        rd_word[`URP_B_RST] = rst_act;
        rd_word[`URP_B_PWR] = pwr_on;
        rd_word[`URP_B_SLOW] = slow_r && conn_r;
        rd_word[`URP_B_ATCH] = atch_r;
        rd_word[`URP_B_ENLOST] = enlost_r;
        rd_word[`URP_B_RSMDONE] = rsmdone_r;
        rd_word[`URP_B_OVLCHG] = ovlchg_r;
        rd_word[`URP_B_RSTDONE] = rstdone_r;
    end
    wire logic rd_hit = reg_rd && hit;

    // registered outputs; unmapped reads return zero
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            reg_rdata <= `URP_RESET_VAL;
            port_power_drive <= 1'b0;
            port_reset_drive <= 1'b0;
            port_resume_drive <= 1'b0;
            port_suspend_drive <= 1'b0;
        end
        else
        begin
            reg_rdata <= rd_hit ? rd_word : `URP_RESET_VAL;
            port_power_drive <= pwr_on;
            port_reset_drive <= rst_act;
            port_resume_drive <= seq_r == URP_RESUMING;
            port_suspend_drive <= susp_r;
        end
    end
endmodule

// ==== core/urp_map.svh ====
// register offsets, field positions and reset values for the root port status block
`ifndef URP_MAP_SVH
`define URP_MAP_SVH
`define URP_OFF_PORT2 8'h58
`define URP_RESET_VAL 32'h00000000
`define URP_B_CONN 0
`define URP_B_EN 1
`define URP_B_SUSP 2
`define URP_B_OVL 3
`define URP_B_RST 4
`define URP_B_PWR 8
`define URP_B_SLOW 9
`define URP_B_ATCH 16
`define URP_B_ENLOST 17
`define URP_B_RSMDONE 18
`define URP_B_OVLCHG 19
`define URP_B_RSTDONE 20
`define URP_RST_NS 10000
`define URP_RSM_NS 20000
`define URP_CLK_NS 25
`define URP_RST_CYC ((`URP_RST_NS + `URP_CLK_NS - 1) / `URP_CLK_NS)
`define URP_RSM_CYC ((`URP_RSM_NS + `URP_CLK_NS - 1) / `URP_CLK_NS)
`define URP_CNT_W 10
`endif

// ==== core/urp_pkg.sv ====
// types shared by the root port status block
package urp_pkg;
    typedef enum logic [1:0] {URP_IDLE, URP_RESETTING, URP_RESUMING} urp_seq_e;
    typedef logic [31:0] urp_word_t;
endpackage

// ==== core/urp_timer.sv ====
// down counter timing port reset and resume signalling
`timescale 1ns/1ps
`include "urp_map.svh"
module urp_timer
    import urp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [`URP_CNT_W-1:0] load_val,
    output logic done
);
    logic [`URP_CNT_W-1:0] cnt_r;
    logic run_r;
    wire logic last = run_r && (cnt_r == `URP_CNT_W'h1);

    // count down once loaded; done pulses on the final count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= last;
            if (load)
            begin
                cnt_r <= load_val;
                run_r <= 1'b1;
            end
            else if (run_r)
            begin
                cnt_r <= cnt_r - `URP_CNT_W'h1;
                run_r <= !last;
            end
        end
    end
endmodule

// ==== bench/urp_port_status_assertions.sv ====
// assertion checker for the root port status block
`timescale 1ns/1ps
`include "urp_map.svh"
module urp_port_status_assertions (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic controller_bus_reset_state,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic device_attached,
    input wire logic overload_input_pin,
    input wire logic power_switch_absent,
    input wire logic overload_guard_absent,
    input wire logic overload_guard_per_port,
    input wire logic port_power_drive,
    input wire logic port_reset_drive,
    input wire logic port_resume_drive,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // accesses to the mapped word; bus reset masks writes
    wire rd = reg_rd && reg_addr == `URP_OFF_PORT2;
    wire wr = reg_wr && reg_addr == `URP_OFF_PORT2 && !controller_bus_reset_state;
    wire busy = port_reset_drive || port_resume_drive;
    logic [10:0] cnt_r;
    // length of the running signalling, judged when it drops
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            cnt_r <= 11'h000;
        else
            cnt_r <= busy ? cnt_r + 11'h001 : 11'h000;
    AST_RSV: assert property ((reg_rdata & 32'hFFE0FCE0) == 32'h0)
        else $error("reserved bits set");
    AST_PWR_ON: assert property (wr && reg_wdata[8] && !reg_wdata[9] |-> ##[1:2] port_power_drive)
        else $error("power not applied");
    AST_PWR_OFF: assert property (wr && reg_wdata[9] && !reg_wdata[8] && !power_switch_absent
        |-> ##[1:2] !port_power_drive)
        else $error("power not removed");
    AST_ABSENT: assert property (rd && power_switch_absent && !controller_bus_reset_state
        |=> reg_rdata[8])
        else $error("power bit low without switching");
    AST_OVL: assert property ((overload_input_pin && overload_guard_per_port
        && !overload_guard_absent)[*4] ##0 rd |=> reg_rdata[3])
        else $error("overload not shown");
    AST_RST_GO: assert property ((device_attached && !busy)[*3] ##0 wr && reg_wdata[4]
        |-> ##[1:3] port_reset_drive)
        else $error("reset signalling not started");
    AST_RST_LEN: assert property ($fell(port_reset_drive) && !controller_bus_reset_state
        |-> cnt_r >= `URP_RST_CYC - 2 && cnt_r <= `URP_RST_CYC + 2)
        else $error("reset signalling length wrong");
    AST_RSM_LEN: assert property ($fell(port_resume_drive) && !controller_bus_reset_state
        |-> cnt_r >= `URP_RSM_CYC - 2 && cnt_r <= `URP_RSM_CYC + 2)
        else $error("resume length wrong");
    // drive outputs lag the sequencer by one register, hence three cycles
    AST_BUSRST: assert property (controller_bus_reset_state[*3] |-> !busy)
        else $error("signalling during bus reset");
    // main scenarios reached
    cover property (wr && reg_wdata[4]);
    cover property ($fell(port_resume_drive));
    cover property (rd && power_switch_absent);
endmodule
bind urp_port_status urp_port_status_assertions u_chk (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .controller_bus_reset_state(controller_bus_reset_state),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .device_attached(device_attached),
    .overload_input_pin(overload_input_pin),
    .power_switch_absent(power_switch_absent),
    .overload_guard_absent(overload_guard_absent),
    .overload_guard_per_port(overload_guard_per_port),
    .port_power_drive(port_power_drive),
    .port_reset_drive(port_reset_drive),
    .port_resume_drive(port_resume_drive),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
);

// ==== bench/urp_dev_model.sv ====
// behavioural usb device hanging on the downstream port
`timescale 1ns/1ps
module urp_dev_model (
    input wire logic clk_sys,
    input wire logic plug,
    input wire logic low_speed,
    input wire logic fault,
    input wire logic port_power_drive,
    output logic device_attached,
    output logic device_is_slow,
    output logic overload_input_pin
);
    initial device_attached = 1'b0;
    initial device_is_slow = 1'b0;
    // shows up only once powered; speed line wanders while absent
    always @(posedge clk_sys)
    begin
        device_attached <= plug && port_power_drive;
        device_is_slow <= device_attached ? low_speed : !device_is_slow;
    end
    assign overload_input_pin = fault;
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the root port status block
`timescale 1ns/1ps
`include "urp_map.svh"
module tb;
    localparam logic [31:0] A = 32'hFFFFFFFF;
    logic clk_sys = 1'b0, resetn = 1'b0, controller_bus_reset_state = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, plug = 1'b1, low_speed = 1'b0, fault = 1'b0;
    logic power_switch_absent = 1'b0, device_fixed_setting = 1'b0;
    logic overload_guard_absent = 1'b0, overload_guard_per_port = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic device_attached, device_is_slow, overload_input_pin;
    logic port_power_drive, port_reset_drive, port_resume_drive, port_suspend_drive;
    int miscompares = 0;
    int num_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    urp_port_status u_dut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .controller_bus_reset_state(controller_bus_reset_state),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .device_attached(device_attached),
        .device_is_slow(device_is_slow),
        .overload_input_pin(overload_input_pin),
        .power_switch_absent(power_switch_absent),
        .overload_guard_absent(overload_guard_absent),
        .overload_guard_per_port(overload_guard_per_port),
        .device_fixed_setting(device_fixed_setting),
        .port_power_drive(port_power_drive),
        .port_reset_drive(port_reset_drive),
        .port_resume_drive(port_resume_drive),
        .port_suspend_drive(port_suspend_drive)
    );
    urp_dev_model u_dev (.clk_sys(clk_sys), .plug(plug), .low_speed(low_speed),
        .fault(fault), .port_power_drive(port_power_drive),
        .device_attached(device_attached), .device_is_slow(device_is_slow),
        .overload_input_pin(overload_input_pin));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one strobe cycle, then a gap so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    // read data is registered, so it is taken one edge later
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        num_checks++;
        if ((reg_rdata & m) !== (e & m))
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, reg_rdata & m, e & m);
        end
        cyc(1);
    endtask
    // direct look at a port level output, taken away from the clock edge
    task automatic chk(input logic g, input logic w);
        num_checks++;
        if (g !== w)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, g, w);
        end
    endtask
    task automatic bus_reset();
        controller_bus_reset_state = 1'b1;
        cyc(4);
        controller_bus_reset_state = 1'b0;
        cyc(4);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // run is about 1300 cycles; a hang is cut well after that
    initial
    begin
        cyc(5000);
        miscompares++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        cyc(2);
        resetn = 1'b1;
        cyc(6);
        wr(8'h5C, A);
        rd(8'h58, 32'h0, A);
        rd(8'h5C, 32'h0, A);
        wr(8'h58, 32'h100);
        cyc(6);
        rd(8'h58, 32'h10101, A);
        wr(8'h58, 32'h10000);
        wr(8'h58, 32'h0);
        rd(8'h58, 32'h101, A);
        wr(8'h58, 32'h10);
        rd(8'h58, 32'h111, A);
        chk(port_reset_drive, 1'b1);
        cyc(`URP_RST_CYC);
        rd(8'h58, 32'h100103, A);
        wr(8'h58, 32'h100000);
        wr(8'h58, 32'h4);
        rd(8'h58, 32'h107, A);
        chk(port_suspend_drive, 1'b1);
        wr(8'h58, 32'h8);
        chk(port_resume_drive, 1'b1);
        cyc(`URP_RSM_CYC);
        rd(8'h58, 32'h40103, A);
        chk(port_resume_drive, 1'b0);
        chk(port_suspend_drive, 1'b0);
        wr(8'h58, 32'h40000);
        fault = 1'b1;
        cyc(6);
        rd(8'h58, 32'hA0109, A);
        fault = 1'b0;
        cyc(6);
        wr(8'h58, 32'hA0000);
        rd(8'h58, 32'h101, A);
        wr(8'h58, 32'h2);
        wr(8'h58, 32'h1);
        rd(8'h58, 32'h101, A);
        wr(8'h58, 32'h200);
        cyc(6);
        rd(8'h58, 32'h10000, A);
        low_speed = 1'b1;
        wr(8'h58, 32'h100);
        cyc(6);
        rd(8'h58, 32'h10301, A);
        bus_reset();
        rd(8'h58, 32'h0, A);
        device_fixed_setting = 1'b1;
        power_switch_absent = 1'b1;
        bus_reset();
        rd(8'h58, 32'h10101, 32'h10101);
        end_of_test();
    end
endmodule
